// ### clock_power_ctrl.sv
/*
  Clock source selection, PLL dividers and phase detector, processor, USB and
  peripheral clock dividers, wake-up timer and power-mode sequencer.
  Assumes oscillator ticks arrive synchronous to clk, each at most once per cycle;
  the analog PLL oscillator is outside and is steered by the up/down outputs.
*/
// Summary of operation
// - Reset runs from internal RC oscillator
// - Software picks main, RC or RTC source
// - Processor clock follows source unless PLL connected
// - Each peripheral has its own divider
// - Pre-divider N from 1 to 256
// - Feedback divider M up to 32768, phase-compared
// - Reset and power-down disable, bypass PLL
// - Power-down wake-ups resume on 4 MHz RC oscillator; Sleep keeps source
// - Wake-up timer qualifies main oscillator
// - Idle, Sleep, Power-down, Deep power-down modes
// - Programmable processor divider after PLL
// - Disabled peripherals get no clock
// - Sleep exit waits 4 or 4096 cycles
// - Sleep entry stops PLL, clears processor and USB dividers
`timescale 1ns/10ps
`default_nettype none
module clock_power_ctrl
  import clock_power_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic srst,
  // Oscillator ticks
  input wire logic main_osc_tick,
  input wire logic internal_rc_osc_tick,
  input wire logic rtc_osc_tick,
  input wire logic current_controlled_osc_tick,
  // Configuration
  input wire logic cfg_wr,
  input wire cfg_t cfg_in,
  // Power mode request and wake
  input wire logic mode_go,
  input wire pm_state_t mode_req,
  input wire logic wake_event,
  // PLL oscillator steering
  output logic current_controlled_osc_up,
  output logic current_controlled_osc_down,
  // Derived clocks (one-cycle ticks)
  output logic pll_source_clock,
  output logic processor_clock,
  output logic usb_clock,
  output logic [NUM_PERIPH-1:0] periph_clock,
  // Status
  output status_t status,
  output pm_state_t power_state
);

  function automatic logic pdiv_hit(input logic [2:0] cnt, input logic [1:0] sel);
    logic hit;
    hit = 1'b0;
    case (sel)
      PDIV_1: hit = 1'b1;
      PDIV_2: hit = (cnt[0] == 1'b0);
      PDIV_4: hit = (cnt[1:0] == 2'h0);
      default: hit = (cnt == 3'h0);
    endcase
    return hit;
  endfunction

  cfg_t cfg_r, cfg_nxt;
  pm_state_t st_r, st_nxt;
  logic [12:0] wake_cnt_r, resume_cnt_r;
  logic [7:0] pre_cnt_r, cpu_cnt_r;
  logic [14:0] fb_cnt_r;
  logic [3:0] usb_cnt_r;
  logic [1:0] fb_seen_r;
  logic [4:0] lock_cnt_r;
  logic pll_src_r, ref_r, fb_r, up_r, dn_r, cpu_r, usb_r;
  logic [NUM_PERIPH-1:0] per_r;

  // Power state decode
  wire osc_off = (st_r == ST_SLEEP) || (st_r == ST_PDOWN) || (st_r == ST_DPDOWN);
  wire deep_off = (st_r == ST_PDOWN) || (st_r == ST_DPDOWN);
  wire clocks_run = (st_r == ST_RUN) || (st_r == ST_IDLE);
  wire sel_main = (cfg_r.src_sel == SRC_MAIN);
  wire sel_rtc = (cfg_r.src_sel == SRC_RTC);

  // Main oscillator counts as usable only once the wake-up timer has expired
  wire main_osc_power = cfg_r.main_osc_on && !osc_off;
  wire main_stable = (wake_cnt_r == WAKE_TERMINAL);
  wire main_gated = main_osc_tick && main_stable;

  // Unused select code 3 falls back to the RC oscillator
  wire raw_src_tick = sel_main ? main_osc_tick : (sel_rtc ? rtc_osc_tick : internal_rc_osc_tick);
  wire sel_tick = sel_main ? main_gated : (sel_rtc ? rtc_osc_tick : internal_rc_osc_tick);

  // PLL dividers and lock
  wire pll_active = cfg_r.pll_enable;
  wire pll_locked = (lock_cnt_r == LOCK_PERIODS);
  wire pll_connected = pll_active && cfg_r.pll_connect;
  wire ref_hit = pll_active && pll_src_r && (pre_cnt_r == cfg_r.pre_div);
  wire fb_hit = pll_active && current_controlled_osc_tick && (fb_cnt_r == cfg_r.mult);
  wire one_fb = (fb_seen_r == 2'h1) || ((fb_seen_r == 2'h0) && fb_r);

  // Processor path: source unless the PLL is both active and connected
  wire core_tick = pll_connected ? current_controlled_osc_tick : pll_src_r;
  wire cpu_hit = core_tick && (cpu_cnt_r >= cfg_r.cpu_div);
  wire usb_hit = pll_connected && current_controlled_osc_tick && (usb_cnt_r >= cfg_r.usb_div);

  // Sleep resume wait depends on which oscillator was in use
  wire [12:0] resume_limit = sel_main ? RESUME_MAIN : RESUME_RC;
  wire resume_done = (resume_cnt_r >= resume_limit);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_RUN: begin
        if (mode_go && (mode_req != ST_WAKE)) begin
          st_nxt = mode_req;
        end
      end
      ST_IDLE: begin
        if (wake_event) begin
          st_nxt = ST_RUN;
        end
      end
      ST_SLEEP, ST_PDOWN, ST_DPDOWN: begin
        if (wake_event) begin
          st_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (resume_done) begin
          st_nxt = ST_RUN;
        end
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  wire enter_low = (st_r == ST_RUN) &&
    ((st_nxt == ST_SLEEP) || (st_nxt == ST_PDOWN) || (st_nxt == ST_DPDOWN));
  wire enter_pdown = (st_r == ST_RUN) && ((st_nxt == ST_PDOWN) || (st_nxt == ST_DPDOWN));
  wire deep_wake = (st_r == ST_DPDOWN) && wake_event;

  always_comb begin
    cfg_nxt = cfg_r;
    if (cfg_wr && (st_r == ST_RUN)) begin
      cfg_nxt = cfg_in;
    end
    if (enter_low) begin
      cfg_nxt.pll_enable = 1'b0;
      cfg_nxt.pll_connect = 1'b0;
      cfg_nxt.cpu_div = 8'h00;
      cfg_nxt.usb_div = 4'h0;
    end
    if (enter_pdown) begin
      cfg_nxt.src_sel = SRC_RC;
      cfg_nxt.main_osc_on = 1'b0;
      cfg_nxt.pll_enable = 1'b0;
    end
    // No retention through deep power-down: wake is a full restart
    if (deep_wake) begin
      cfg_nxt = CFG_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_r <= CFG_RESET;
      st_r <= ST_RUN;
    end else begin
      cfg_r <= cfg_nxt;
      st_r <= st_nxt;
    end
  end

  // Wake-up timer restarts whenever the main oscillator loses power
  always_ff @(posedge clk) begin
    if (srst || !main_osc_power) begin
      wake_cnt_r <= 13'h0000;
    end else if (main_osc_tick && !main_stable) begin
      wake_cnt_r <= wake_cnt_r + 13'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || (st_r != ST_WAKE)) begin
      resume_cnt_r <= 13'h0000;
    end else if (raw_src_tick && !resume_done) begin
      resume_cnt_r <= resume_cnt_r + 13'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pll_src_r <= 1'b0;
    end else begin
      pll_src_r <= sel_tick && !osc_off;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !pll_active) begin
      pre_cnt_r <= 8'h00;
    end else if (pll_src_r) begin
      pre_cnt_r <= ref_hit ? 8'h00 : pre_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !pll_active) begin
      fb_cnt_r <= 15'h0000;
    end else if (current_controlled_osc_tick) begin
      fb_cnt_r <= fb_hit ? 15'h0000 : fb_cnt_r + 15'h0001;
    end
  end

  // Phase-frequency compare: coincident edges cancel
  always_ff @(posedge clk) begin
    if (srst) begin
      ref_r <= 1'b0;
      fb_r <= 1'b0;
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end else begin
      ref_r <= ref_hit;
      fb_r <= fb_hit;
      up_r <= ref_hit && !fb_hit;
      dn_r <= fb_hit && !ref_hit;
    end
  end

  // Lock: a run of reference periods each holding exactly one feedback edge
  always_ff @(posedge clk) begin
    if (srst || !pll_active) begin
      fb_seen_r <= 2'h0;
      lock_cnt_r <= 5'h00;
    end else if (ref_r) begin
      fb_seen_r <= 2'h0;
      if (!one_fb) begin
        lock_cnt_r <= 5'h00;
      end else if (!pll_locked) begin
        lock_cnt_r <= lock_cnt_r + 5'h01;
      end
    end else if (fb_r && (fb_seen_r != 2'h2)) begin
      fb_seen_r <= fb_seen_r + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_cnt_r <= 8'h00;
      usb_cnt_r <= 4'h0;
    end else begin
      if (core_tick) begin
        cpu_cnt_r <= cpu_hit ? 8'h00 : cpu_cnt_r + 8'h01;
      end
      if (pll_connected && current_controlled_osc_tick) begin
        usb_cnt_r <= usb_hit ? 4'h0 : usb_cnt_r + 4'h1;
      end
    end
  end

  // Processor halts in Idle while peripherals keep running
  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_r <= 1'b0;
      usb_r <= 1'b0;
    end else begin
      cpu_r <= cpu_hit && (st_r == ST_RUN);
      usb_r <= usb_hit && clocks_run;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_per
      logic [2:0] per_cnt_r;
      wire base_tick = cpu_hit && clocks_run;
      always_ff @(posedge clk) begin
        if (srst) begin
          per_cnt_r <= 3'h0;
          per_r[gi] <= 1'b0;
        end else begin
          if (base_tick) begin
            per_cnt_r <= per_cnt_r + 3'h1;
          end
          per_r[gi] <= base_tick && cfg_r.per_on[gi] && pdiv_hit(per_cnt_r, cfg_r.per_div[gi]);
        end
      end
    end
  endgenerate

  assign current_controlled_osc_up = up_r;
  assign current_controlled_osc_down = dn_r;
  assign pll_source_clock = pll_src_r;
  assign processor_clock = cpu_r;
  assign usb_clock = usb_r;
  assign periph_clock = per_r;
  assign power_state = st_r;

  // One driver for the whole status word
  assign status = '{
    pll_locked: pll_locked,
    pll_active: pll_active,
    pll_connected: pll_connected,
    main_stable: main_stable,
    cpu_run: (st_r == ST_RUN),
    rc_output_en: !osc_off,
    rc_power: !deep_off,
    flash_power: !deep_off,
    regulator_on: (st_r != ST_DPDOWN),
    main_osc_power: main_osc_power
  };

endmodule
`default_nettype wire

// ### clock_power_ctrl_note_end.sv
`default_nettype none
`default_nettype wire

// ### clock_power_pkg.sv
/*
  Shared constants and types for the clock source, PLL and power control block.
  Assumes one 20 MHz system clock; every oscillator reaches the block as a one-cycle tick.
*/
`default_nettype none
package clock_power_pkg;
  localparam int NUM_PERIPH = 4;

  // Oscillator choices for the PLL input
  localparam logic [1:0] SRC_RC = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_RTC = 2'h2;

  // Wake-up timer terminal count, in main oscillator cycles
  localparam logic [12:0] WAKE_TERMINAL = 13'h1000;
  // Resume delays after Sleep, in source cycles
  localparam logic [12:0] RESUME_RC = 13'h0004;
  localparam logic [12:0] RESUME_MAIN = 13'h1000;
  // Reference periods with exactly one feedback edge before lock is shown
  localparam logic [4:0] LOCK_PERIODS = 5'h10;

  // Peripheral divider select: 0 -> /1, 1 -> /2, 2 -> /4, 3 -> /8
  localparam logic [1:0] PDIV_1 = 2'h0;
  localparam logic [1:0] PDIV_2 = 2'h1;
  localparam logic [1:0] PDIV_4 = 2'h2;

  // Power states; Gray steps along run -> idle -> sleep -> power-down -> deep -> wake
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_IDLE = 3'h1,
    ST_SLEEP = 3'h3,
    ST_PDOWN = 3'h2,
    ST_DPDOWN = 3'h6,
    ST_WAKE = 3'h7
  } pm_state_t;

  // Software configuration; pre_div holds N-1, mult holds M-1, cpu_div and usb_div hold count-1
  typedef struct packed {
    logic [1:0] src_sel;
    logic main_osc_on;
    logic pll_enable;
    logic pll_connect;
    logic [7:0] pre_div;
    logic [14:0] mult;
    logic [7:0] cpu_div;
    logic [3:0] usb_div;
    logic [NUM_PERIPH-1:0][1:0] per_div;
    logic [NUM_PERIPH-1:0] per_on;
  } cfg_t;

  localparam cfg_t CFG_RESET = '0;

  typedef struct packed {
    logic pll_locked;
    logic pll_active;
    logic pll_connected;
    logic main_stable;
    logic cpu_run;
    logic rc_output_en;
    logic rc_power;
    logic flash_power;
    logic regulator_on;
    logic main_osc_power;
  } status_t;
endpackage
`default_nettype wire

// ### clock_power_props.sv
/*
  Concurrent checks on the ports of clock_power_ctrl.
  Assumes one clk domain with synchronous active-high srst; bound below.
*/
`timescale 1ns/10ps
`default_nettype none
module clock_power_props
  import clock_power_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic main_osc_tick,
  input wire logic mode_go,
  input wire pm_state_t mode_req,
  input wire logic wake_event,
  input wire logic current_controlled_osc_up,
  input wire logic current_controlled_osc_down,
  input wire logic pll_source_clock,
  input wire logic processor_clock,
  input wire logic usb_clock,
  input wire status_t status,
  input wire pm_state_t power_state
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (srst);
  logic [12:0] mcnt_r;
  // Never below the design's own count, so early stability is caught
  always_ff @(posedge clk) begin
    if (srst || !status.main_osc_power) begin
      mcnt_r <= 13'h0000;
    end else if (main_osc_tick && mcnt_r != 13'h1fff) begin
      mcnt_r <= mcnt_r + 13'h0001;
    end
  end
  property p_reset_run;
    $fell(srst) |-> power_state == ST_RUN && !status.pll_active && status.rc_power;
  endproperty
  a_reset_run: assert property (p_reset_run)
    else $error("state after reset wrong");
  property p_sleep_entry;
    mode_go && power_state == ST_RUN && mode_req == ST_SLEEP
      |=> power_state == ST_SLEEP && !status.pll_active && !status.pll_connected;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entry wrong");
  property p_pdown_entry;
    mode_go && power_state == ST_RUN && mode_req == ST_PDOWN
      |=> power_state == ST_PDOWN && !status.pll_active && !status.main_osc_power;
  endproperty
  a_pdown_entry: assert property (p_pdown_entry)
    else $error("power-down entry wrong");
  property p_idle_wake;
    power_state == ST_IDLE && wake_event |=> power_state == ST_RUN;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("idle did not wake");
  property p_low_quiet;
    power_state inside {ST_SLEEP, ST_PDOWN, ST_DPDOWN} && $past(power_state) == power_state
      |-> !pll_source_clock && !processor_clock && !usb_clock;
  endproperty
  a_low_quiet: assert property (p_low_quiet)
    else $error("clock ticks in low power");
  property p_cpu_run;
    processor_clock |-> power_state == ST_RUN || $past(power_state) == ST_RUN;
  endproperty
  a_cpu_run: assert property (p_cpu_run)
    else $error("processor tick outside run");
  property p_main_stable;
    status.main_stable |-> mcnt_r >= WAKE_TERMINAL;
  endproperty
  a_main_stable: assert property (p_main_stable)
    else $error("main stable too early");
  property p_steer_excl;
    !(current_controlled_osc_up && current_controlled_osc_down);
  endproperty
  a_steer_excl: assert property (p_steer_excl)
    else $error("up and down together");
  property p_usb_conn;
    usb_clock |-> status.pll_connected || $past(status.pll_connected);
  endproperty
  a_usb_conn: assert property (p_usb_conn)
    else $error("usb tick without pll");
  c_locked: cover property (status.pll_locked);
  c_wake: cover property (power_state == ST_WAKE ##1 power_state == ST_RUN);
  c_stable: cover property ($rose(status.main_stable));
endmodule
bind clock_power_ctrl clock_power_props u_props (.clk, .srst, .main_osc_tick, .mode_go, .mode_req,
  .wake_event, .current_controlled_osc_up, .current_controlled_osc_down, .pll_source_clock, .processor_clock,
  .usb_clock, .status, .power_state);
`default_nettype wire

// ### testbench.sv
/*
  Self-checking bench for clock_power_ctrl.
  Assumes 20 MHz clk; RC tick every 4 cycles, RTC every 16, main every cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench
  import clock_power_pkg::*;
;
  logic clk, srst, main_osc_tick, internal_rc_osc_tick, rtc_osc_tick, current_controlled_osc_tick, cfg_wr, mode_go;
  logic wake_event, current_controlled_osc_up, current_controlled_osc_down;
  logic pll_source_clock, processor_clock, usb_clock, main_en;
  logic [NUM_PERIPH-1:0] periph_clock;
  cfg_t cfg_in, c;
  pm_state_t mode_req, power_state;
  status_t status;
  int miscompares, check_count, cyc, osc_per, n, n_src, n_cpu, n_dn, n_usb;
  int n_per [NUM_PERIPH];
  clock_power_ctrl u_dut (.clk, .srst, .main_osc_tick, .internal_rc_osc_tick, .rtc_osc_tick,
    .current_controlled_osc_tick, .cfg_wr, .cfg_in, .mode_go, .mode_req, .wake_event, .current_controlled_osc_up,
    .current_controlled_osc_down, .pll_source_clock, .processor_clock, .usb_clock, .periph_clock, .status,
    .power_state);
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc <= cyc + 1;
    internal_rc_osc_tick <= (cyc % 4 == 0);
    rtc_osc_tick <= (cyc % 16 == 0);
    main_osc_tick <= main_en;
    current_controlled_osc_tick <= (osc_per != 0) && (cyc % osc_per == 0);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr();
    @(negedge clk);
    cfg_in = c;
    cfg_wr = 1;
    @(negedge clk);
    cfg_wr = 0;
  endtask
  task automatic go(input pm_state_t m, input logic wk);
    @(negedge clk);
    mode_req = m;
    mode_go = !wk;
    wake_event = wk;
    @(negedge clk);
    mode_go = 0;
    wake_event = 0;
  endtask
  task automatic meas(input int len);
    n_src = 0;
    n_cpu = 0;
    n_dn = 0;
    n_usb = 0;
    n_per = '{default: 0};
    repeat (len) begin
      @(posedge clk);
      #1;
      n_src += int'(pll_source_clock);
      n_cpu += int'(processor_clock);
      n_dn += int'(current_controlled_osc_down);
      n_usb += int'(usb_clock);
      for (int i = 0; i < NUM_PERIPH; i++) n_per[i] += int'(periph_clock[i]);
    end
  endtask
  task automatic wait_st(input pm_state_t s, input int lim);
    n = 0;
    while (power_state !== s && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(power_state, s);
  endtask
  task automatic t_rst();
    srst = 1;
    repeat (4) @(negedge clk);
    srst = 0;
    @(negedge clk);
    chk(power_state, ST_RUN);
    chk(status.pll_active, 0);
    c = CFG_RESET;
    meas(160);
    chk(n_src, 40);
    chk(n_cpu, 40);
    chk(n_per[0], 0);
  endtask
  task automatic t_pll();
    c.pll_enable = 1;
    c.pre_div = 8'h01;
    c.mult = 15'h0003;
    osc_per = 1;
    wr();
    meas(160);
    chk(n_cpu, 40);
    chk(n_dn != 0, 1);
    chk(status.pll_locked, 0);
    osc_per = 2;
    // Feedback now one edge per reference period of 8 cycles
    n = 0;
    while (status.pll_locked !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    chk(status.pll_locked, 1);
    c.pll_connect = 1;
    wr();
    meas(160);
    chk(n_cpu, 80);
    chk(n_usb, 80);
    c.cpu_div = 8'h01;
    wr();
    meas(160);
    chk(n_cpu, 40);
    chk(n_usb, 80);
  endtask
  task automatic t_sleep_irc();
    go(ST_SLEEP, 0);
    chk(power_state, ST_SLEEP);
    chk(status.pll_connected, 0);
    chk(status.rc_output_en, 0);
    chk(status.cpu_run, 0);
    chk(status.flash_power, 1);
    meas(40);
    chk(n_cpu + n_src + n_usb, 0);
    go(ST_RUN, 1);
    wait_st(ST_RUN, 100);
    chk_rng(n, 12, 22);
    meas(160);
    chk(n_cpu, 40);
  endtask
  task automatic t_main();
    c = CFG_RESET;
    c.src_sel = SRC_RTC;
    wr();
    meas(160);
    chk(n_src, 10);
    c.src_sel = SRC_MAIN;
    c.main_osc_on = 1;
    c.per_div[1] = PDIV_2;
    c.per_div[2] = PDIV_4;
    c.per_on = 4'h7;
    main_en = 1;
    wr();
    meas(160);
    chk(n_src, 0);
    n = 0;
    while (status.main_stable !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk(status.main_stable, 1);
    c.cpu_div = 8'h03;
    wr();
    meas(160);
    chk(n_src, 160);
    chk(n_cpu, 40);
    chk(n_per[0], 40);
    chk(n_per[1], 20);
    chk(n_per[2], 10);
    chk(n_per[3], 0);
    go(ST_SLEEP, 0);
    go(ST_RUN, 1);
    wait_st(ST_RUN, 5000);
    chk_rng(n, 4088, 4100);
  endtask
  task automatic t_down();
    go(ST_PDOWN, 0);
    chk(status.main_osc_power, 0);
    chk(status.rc_power, 0);
    go(ST_RUN, 1);
    wait_st(ST_RUN, 100);
    chk_rng(n, 12, 22);
    meas(160);
    chk(n_src, 40);
    chk(status.main_stable, 0);
    c = CFG_RESET;
    c.per_on = 4'h1;
    wr();
    go(ST_IDLE, 0);
    meas(160);
    chk(n_cpu, 0);
    chk(n_per[0], 40);
    go(ST_RUN, 1);
    chk(power_state, ST_RUN);
    go(ST_DPDOWN, 0);
    chk(power_state, ST_DPDOWN);
    chk(status.regulator_on, 0);
    go(ST_RUN, 1);
    wait_st(ST_RUN, 100);
    meas(160);
    chk(n_per[0], 0);
    chk(n_src, 40);
  endtask
  task automatic results();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {srst, cfg_wr, mode_go, wake_event, main_en, cyc, osc_per} = '0;
    {main_osc_tick, internal_rc_osc_tick, rtc_osc_tick, current_controlled_osc_tick} = '0;
    cfg_in = CFG_RESET;
    mode_req = ST_RUN;
    t_rst();
    t_pll();
    t_sleep_irc();
    t_main();
    t_down();
    c.pll_enable = 1;
    wr();
    t_rst();
    results();
  end
  initial begin
    #(50 * 30000);
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
